// ==== rtl/ncq_params.svh ====
// Purpose: Constants of the network control-queue command unit
// Assumes: Byte addresses on a 32-bit AXI4-Lite slave
// Notes:   Offsets, fields, codes and reset values only
`ifndef NCQ_PARAMS_SVH
`define NCQ_PARAMS_SVH

// Command classes and codes
`define NCQ_CLASS_ANNOUNCE   8'h03
`define NCQ_CMD_ANNOUNCE_ACK 8'h00
`define NCQ_CLASS_MQ         8'h04
`define NCQ_CMD_PAIRS_SET    8'h00
`define NCQ_CLASS_OFFLOAD    8'h05
`define NCQ_CMD_OFFLOAD_SET  8'h00
`define NCQ_PAIRS_MIN        16'h0001
`define NCQ_PAIRS_MAX        16'h8000

// Acknowledge codes
`define NCQ_ACK_OK           8'h00
`define NCQ_ACK_ERR          8'h01

// Register byte offsets
`define NCQ_REG_FEATURES     8'h00
`define NCQ_REG_STATUS       8'h04
`define NCQ_REG_ANNOUNCE     8'h08
`define NCQ_REG_MAX_PAIRS    8'h0C
`define NCQ_REG_PAIRS        8'h10
`define NCQ_REG_OFFL_LO      8'h14
`define NCQ_REG_OFFL_HI      8'h18
`define NCQ_REG_OFFL_FEAT_LO 8'h1C
`define NCQ_REG_OFFL_FEAT_HI 8'h20
`define NCQ_REG_COUNTS       8'h24

// Feature register fields
`define NCQ_FEAT_CTRL_VQ     0
`define NCQ_FEAT_ANNOUNCE    1
`define NCQ_FEAT_MQ          2
`define NCQ_FEAT_OFFLOADS    3
`define NCQ_FEAT_LEGACY      4
`define NCQ_FEAT_BIG_ENDIAN  5
`define NCQ_FEAT_WIDTH       6

// Status register fields
`define NCQ_STAT_MQ_ON       0
`define NCQ_STAT_ANNOUNCE    1

// Bus answers and reset values
`define NCQ_RESP_OKAY        2'h0
`define NCQ_RESP_SLVERR      2'h2
`define NCQ_MAX_PAIRS_RESET  16'h0001

`endif

// ==== rtl/ncq_pkg.sv ====
// Purpose: Types of the network control-queue command unit
// Assumes: Included header supplies widths of fields
// Notes:   One packed struct holds all state of the command unit except the flow table's
`include "ncq_params.svh"

package ncq_pkg;

    typedef enum logic [1:0] {
        NCQ_IDLE = 2'b01,
        NCQ_ACK  = 2'b10
    } ncq_cmd_state_type;

    typedef struct packed {
        ncq_cmd_state_type            st;
        logic                         cmdReady;
        logic                         ackValid;
        logic [7:0]                   ackCode;
        logic                         applyPairs;
        logic [15:0]                  pairsPend;
        logic [15:0]                  pairs;
        logic [15:0]                  maxPairs;
        logic [63:0]                  offl;
        logic [63:0]                  offlFeat;
        logic [`NCQ_FEAT_WIDTH-1:0]   feat;
        logic                         announce;
        logic                         cfgChange;
        logic [15:0]                  cmdCount;
        logic [15:0]                  errCount;
        logic                         awHeld;
        logic [7:0]                   awAddr;
        logic                         wHeld;
        logic [31:0]                  wData;
        logic [3:0]                   wStrb;
        logic                         awready;
        logic                         wready;
        logic                         bvalid;
        logic [1:0]                   bresp;
        logic                         arready;
        logic                         rvalid;
        logic [31:0]                  rdata;
        logic [1:0]                   rresp;
    } ncq_state_type;

endpackage

// ==== rtl/ncq_flow_table.sv ====
// Purpose: Flow-to-queue steering table for received packets
// Assumes: Flow ids are hashed upstream into FLOW_BITS bits
// Notes:   Answer is registered one cycle after the lookup
`timescale 1ns/10ps
`default_nettype none

module ncq_flow_table #(
    parameter int FLOW_BITS = 6,
    parameter int QW        = 16
) (
    input  wire logic                 sys_clk,     // System clock
    input  wire logic                 rst,         // Async reset
    input  wire logic                 learnValid,  // Tx packet seen
    input  wire logic [FLOW_BITS-1:0] learnFlow,   // Its flow id
    input  wire logic [QW-1:0]        learnQueue,  // Its tx queue
    input  wire logic                 lookupValid, // Rx packet arrives
    input  wire logic [FLOW_BITS-1:0] lookupFlow,  // Its flow id
    input  wire logic [QW-1:0]        pairs,       // Enabled pair count
    output logic                      resultValid, // Queue chosen
    output logic [QW-1:0]             resultQueue  // Rx queue, 0-based
);
    import ncq_pkg::*;

    localparam int ENTRIES = 1 << FLOW_BITS;

    typedef struct packed {
        logic [ENTRIES-1:0]         hit;
        logic [ENTRIES-1:0][QW-1:0] q;
        logic [QW-1:0]              rr;
        logic                       rv;
        logic [QW-1:0]              rq;
    } ncq_flow_state_type;

    ncq_flow_state_type s, n;

    always_comb begin
        logic [QW-1:0] rrNow;
        rrNow = (s.rr < pairs) ? s.rr : '0;
        n = s;
        n.rv = lookupValid;
        if (learnValid) begin
            n.hit[learnFlow] = 1'b1;
            n.q[learnFlow]   = learnQueue;
        end
        if (lookupValid) begin
            if (pairs <= QW'(1)) begin
                n.rq = '0;
            end else if (s.hit[lookupFlow]
                         && s.q[lookupFlow] < pairs) begin
                n.rq = s.q[lookupFlow];
            end else begin
                n.rq = rrNow;
                n.rr = (rrNow + QW'(1) >= pairs) ? '0 : rrNow + QW'(1);
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign resultValid = s.rv;
    assign resultQueue = s.rq;

endmodule

`default_nettype wire

// ==== rtl/ncq_cmd_unit.sv ====
// Purpose: Control-queue command handler of a virtual network device
// Assumes: Command buffers arrive already split into class, code, data
// Notes:   Summary of operation follows
// Summary of operation
// - Command: class, code, payload, then ack byte
// - Raise announce only with announce feature
// - Announce acknowledge clears bit before returning
// - Pair-set carries 16-bit little-endian count
// - Reset disables multiqueue; applies when consumed
// - Rx flow steered to its tx queue
// - Unknown flows go to any enabled queue
// - Before pair-set, deliver only first queue
// - After used, no queue above pair count
// - Offload-set 64-bit mask enables or disables
// - Negotiated offload features start enabled
// - Legacy payloads use guest native byte order
`timescale 1ns/10ps
`default_nettype none
`include "ncq_params.svh"

module ncq_cmd_unit
    import ncq_pkg::*;
#(
    parameter int FLOW_BITS = 6
) (
    input  wire logic                 sys_clk,       // System clock
    input  wire logic                 rst,           // Async reset
    input  wire logic                 awvalid,       // AXI write address
    output logic                      awready,       // AXI write address
    input  wire logic [7:0]           awaddr,        // Byte address
    input  wire logic                 wvalid,        // AXI write data
    output logic                      wready,        // AXI write data
    input  wire logic [31:0]          wdata,         // Write word
    input  wire logic [3:0]           wstrb,         // Byte enables
    output logic                      bvalid,        // Write response
    input  wire logic                 bready,        // Write response
    output logic [1:0]                bresp,         // Write answer
    input  wire logic                 arvalid,       // AXI read address
    output logic                      arready,       // AXI read address
    input  wire logic [7:0]           araddr,        // Byte address
    output logic                      rvalid,        // Read data
    input  wire logic                 rready,        // Read data
    output logic [31:0]               rdata,         // Read word
    output logic [1:0]                rresp,         // Read answer
    input  wire logic                 cmdValid,      // Command offered
    output logic                      cmdReady,      // Command taken
    input  wire logic [7:0]           cmdClass,      // Class byte
    input  wire logic [7:0]           cmdCode,       // Command byte
    input  wire logic [63:0]          cmdData,       // Payload, byte 0 low
    output logic                      ackValid,      // Ack byte ready
    input  wire logic                 ackReady,      // Buffer returned
    output logic [7:0]                ackCode,       // Ack byte
    output logic                      cfgChange,     // Config changed
    input  wire logic                 txValid,       // Tx packet seen
    input  wire logic [FLOW_BITS-1:0] txFlow,        // Its flow id
    input  wire logic [15:0]          txQueue,       // Its tx queue
    input  wire logic                 rxValid,       // Rx packet arrives
    input  wire logic [FLOW_BITS-1:0] rxFlow,        // Its flow id
    output logic                      rxQueueValid,  // Rx queue chosen
    output logic [15:0]               rxQueue,       // Rx queue, 0-based
    output logic [15:0]               pairsActive,   // Enabled pairs
    output logic [63:0]               offloadsActive // Offload mask
);
    import ncq_pkg::*;

    ncq_state_type s, n;

    function automatic logic [63:0] swap64(input logic [63:0] v);
        logic [63:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[8*i +: 8] = v[8*(7-i) +: 8];
        end
        return r;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    logic        cmdTake;
    logic        bigGuest;
    logic [63:0] payload;
    logic [15:0] reqPairs;
    logic        annCmd;
    logic        mqCmd;
    logic        offlCmd;
    logic        doWrite;
    logic        annWrite;

    always_comb begin
        cmdTake  = cmdValid && s.cmdReady;
        bigGuest = s.feat[`NCQ_FEAT_LEGACY] && s.feat[`NCQ_FEAT_BIG_ENDIAN];
        payload  = bigGuest ? swap64(cmdData) : cmdData;
        reqPairs = bigGuest ? {cmdData[7:0], cmdData[15:8]}
                            : cmdData[15:0];
        annCmd   = cmdClass == `NCQ_CLASS_ANNOUNCE
                   && cmdCode == `NCQ_CMD_ANNOUNCE_ACK;
        mqCmd    = cmdClass == `NCQ_CLASS_MQ
                   && cmdCode == `NCQ_CMD_PAIRS_SET;
        offlCmd  = cmdClass == `NCQ_CLASS_OFFLOAD
                   && cmdCode == `NCQ_CMD_OFFLOAD_SET;
        doWrite  = s.awHeld && s.wHeld && !s.bvalid;
        annWrite = doWrite && s.awAddr == `NCQ_REG_ANNOUNCE
                   && s.wStrb[0] && s.wData[`NCQ_STAT_ANNOUNCE];
    end

    always_comb begin
        n = s;
        n.cfgChange = 1'b0;

        // Command engine
        case (s.st)
            NCQ_IDLE: begin
                if (cmdTake) begin
                    n.st       = NCQ_ACK;
                    n.ackCode  = `NCQ_ACK_ERR;
                    n.cmdCount = s.cmdCount + 16'h0001;
                    if (annCmd && s.feat[`NCQ_FEAT_ANNOUNCE]) begin
                        n.announce = 1'b0;
                        n.ackCode  = `NCQ_ACK_OK;
                    end else if (mqCmd && s.feat[`NCQ_FEAT_MQ]) begin
                        if (reqPairs >= `NCQ_PAIRS_MIN
                            && reqPairs <= s.maxPairs) begin
                            n.pairsPend  = reqPairs;
                            n.applyPairs = 1'b1;
                            n.ackCode    = `NCQ_ACK_OK;
                        end
                    end else if (offlCmd
                                 && s.feat[`NCQ_FEAT_OFFLOADS]) begin
                        n.offl    = payload;
                        n.ackCode = `NCQ_ACK_OK;
                    end
                    if (n.ackCode != `NCQ_ACK_OK) begin
                        n.errCount = s.errCount + 16'h0001;
                    end
                end
            end
            NCQ_ACK: begin
                if (ackReady) begin
                    n.st = NCQ_IDLE;
                    if (s.applyPairs) begin
                        n.pairs = s.pairsPend;
                    end
                    n.applyPairs = 1'b0;
                end
            end
            default: begin
                n.st = NCQ_IDLE;
            end
        endcase
        n.cmdReady = n.st == NCQ_IDLE;
        n.ackValid = n.st == NCQ_ACK;

        // Register writes
        if (awvalid && s.awready) begin
            n.awHeld = 1'b1;
            n.awAddr = awaddr;
        end
        if (wvalid && s.wready) begin
            n.wHeld = 1'b1;
            n.wData = wdata;
            n.wStrb = wstrb;
        end
        if (doWrite) begin
            n.awHeld = 1'b0;
            n.wHeld  = 1'b0;
            n.bvalid = 1'b1;
            n.bresp  = `NCQ_RESP_OKAY;
            case (s.awAddr)
                `NCQ_REG_FEATURES: begin
                    n.feat = (`NCQ_FEAT_WIDTH)'(merge({26'h0, s.feat},
                                                      s.wData, s.wStrb));
                end
                `NCQ_REG_ANNOUNCE: begin
                end
                `NCQ_REG_MAX_PAIRS: begin
                    n.maxPairs = 16'(merge({16'h0, s.maxPairs}, s.wData,
                                           s.wStrb));
                end
                `NCQ_REG_OFFL_FEAT_LO: begin
                    n.offlFeat[31:0] = merge(s.offlFeat[31:0], s.wData,
                                             s.wStrb);
                    n.offl[31:0] = n.offlFeat[31:0];
                end
                `NCQ_REG_OFFL_FEAT_HI: begin
                    n.offlFeat[63:32] = merge(s.offlFeat[63:32],
                                              s.wData, s.wStrb);
                    n.offl[63:32] = n.offlFeat[63:32];
                end
                default: begin
                    n.bresp = `NCQ_RESP_SLVERR;
                end
            endcase
        end
        if (s.bvalid && bready) begin
            n.bvalid = 1'b0;
        end

        // Set wins over a same-cycle acknowledge clear
        if (annWrite && s.feat[`NCQ_FEAT_ANNOUNCE]
            && s.feat[`NCQ_FEAT_CTRL_VQ]) begin
            n.announce = 1'b1;
            n.cfgChange = !s.announce;
        end

        // Register reads
        if (arvalid && s.arready) begin
            n.rvalid = 1'b1;
            n.rresp  = `NCQ_RESP_OKAY;
            case (araddr)
                `NCQ_REG_FEATURES:     n.rdata = {26'h0, s.feat};
                `NCQ_REG_STATUS:       n.rdata = {30'h0, s.announce,
                                                  s.pairs > 16'h0001};
                `NCQ_REG_ANNOUNCE:     n.rdata = 32'h0;
                `NCQ_REG_MAX_PAIRS:    n.rdata = {16'h0, s.maxPairs};
                `NCQ_REG_PAIRS:        n.rdata = {16'h0, s.pairs};
                `NCQ_REG_OFFL_LO:      n.rdata = s.offl[31:0];
                `NCQ_REG_OFFL_HI:      n.rdata = s.offl[63:32];
                `NCQ_REG_OFFL_FEAT_LO: n.rdata = s.offlFeat[31:0];
                `NCQ_REG_OFFL_FEAT_HI: n.rdata = s.offlFeat[63:32];
                `NCQ_REG_COUNTS:       n.rdata = {s.errCount, s.cmdCount};
                default: begin
                    n.rdata = 32'h0;
                    n.rresp = `NCQ_RESP_SLVERR;
                end
            endcase
        end else if (s.rvalid && rready) begin
            n.rvalid = 1'b0;
        end

        n.awready = !n.awHeld && !n.bvalid;
        n.wready  = !n.wHeld && !n.bvalid;
        n.arready = !n.rvalid;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s          <= '0;
            s.st       <= NCQ_IDLE;
            s.cmdReady <= 1'b1;
            s.pairs    <= `NCQ_PAIRS_MIN;
            s.pairsPend <= `NCQ_PAIRS_MIN;
            s.maxPairs <= `NCQ_MAX_PAIRS_RESET;
            s.awready  <= 1'b1;
            s.wready   <= 1'b1;
            s.arready  <= 1'b1;
        end else begin
            s <= n;
        end
    end

    ncq_flow_table #(
        .FLOW_BITS (FLOW_BITS),
        .QW        (16)
    ) flowTable (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .learnValid  (txValid),
        .learnFlow   (txFlow),
        .learnQueue  (txQueue),
        .lookupValid (rxValid),
        .lookupFlow  (rxFlow),
        .pairs       (s.pairs),
        .resultValid (rxQueueValid),
        .resultQueue (rxQueue)
    );

    assign awready        = s.awready;
    assign wready         = s.wready;
    assign bvalid         = s.bvalid;
    assign bresp          = s.bresp;
    assign arready        = s.arready;
    assign rvalid         = s.rvalid;
    assign rdata          = s.rdata;
    assign rresp          = s.rresp;
    assign cmdReady       = s.cmdReady;
    assign ackValid       = s.ackValid;
    assign ackCode        = s.ackCode;
    assign cfgChange      = s.cfgChange;
    assign pairsActive    = s.pairs;
    assign offloadsActive = s.offl;

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence cmdTakenSeq;
        cmdValid && cmdReady;
    endsequence

    sequence ackHeldSeq;
        ackValid && !ackReady;
    endsequence

    announce_gate_a: assert property (
        $rose(s.announce) |->
            $past(s.feat[`NCQ_FEAT_ANNOUNCE] && s.feat[`NCQ_FEAT_CTRL_VQ]))
        else $error("announce raised without feature");

    announce_clear_a: assert property (
        cmdTakenSeq ##0 (annCmd && s.feat[`NCQ_FEAT_ANNOUNCE]
                         && !annWrite) |=> !s.announce && ackValid)
        else $error("announce not cleared before ack");

    ack_follows_a: assert property (
        cmdTakenSeq |=> ackValid && !cmdReady)
        else $error("no ack after command");

    ack_stable_a: assert property (
        ackHeldSeq |=> ackValid && $stable(ackCode))
        else $error("ack dropped or changed early");

    pairs_range_a: assert property (
        pairsActive >= `NCQ_PAIRS_MIN && pairsActive <= `NCQ_PAIRS_MAX)
        else $error("pair count out of range");

    pairs_when_used_a: assert property (
        $changed(pairsActive) |-> $past(ackValid && ackReady))
        else $error("pair count changed before buffer used");

    bad_pairs_a: assert property (
        cmdTakenSeq ##0 (mqCmd && reqPairs == 16'h0000) |=>
            ackCode == `NCQ_ACK_ERR ##1 $stable(pairsActive))
        else $error("zero pair count accepted");

    offload_set_a: assert property (
        cmdTakenSeq ##0 (offlCmd && s.feat[`NCQ_FEAT_OFFLOADS]) |=>
            offloadsActive == $past(payload) && ackCode == `NCQ_ACK_OK)
        else $error("offload mask not applied");

    rx_range_a: assert property (
        rxQueueValid |-> rxQueue < $past(pairsActive))
        else $error("rx queue above pair count");

    first_queue_a: assert property (
        rxQueueValid && $past(pairsActive) == 16'h0001 |->
            rxQueue == 16'h0000)
        else $error("rx queue not first while single pair");

endmodule

`default_nettype wire

// ==== bench/ncq_guest_drv.sv ====
// Purpose: Guest driver model on the command port
// Assumes: One command at a time, payload byte 0 in the low bits
// Notes:   Returned buffer is taken back after a random stall
`timescale 1ns/10ps
`default_nettype none
module ncq_guest_drv (
    input  wire logic   sys_clk,  // System clock
    output logic        cmdValid, // Command offered
    input  wire logic   cmdReady, // Command taken
    output logic [7:0]  cmdClass, // Class byte
    output logic [7:0]  cmdCode,  // Command byte
    output logic [63:0] cmdData,  // Payload
    input  wire logic   ackValid, // Ack byte ready
    output logic        ackReady  // Buffer returned
);
    initial begin
        cmdValid = 1'b0;
        cmdClass = 8'h00;
        cmdCode  = 8'h00;
        cmdData  = 64'h0;
        ackReady = 1'b0;
    end
    // Whole buffer offered, held until taken, then ack byte collected
    task automatic send(input logic [7:0] c, input logic [7:0] k,
                        input logic [63:0] d);
        cmdClass <= c;
        cmdCode  <= k;
        cmdData  <= d;
        cmdValid <= 1'b1;
        do @(posedge sys_clk); while (!cmdReady);
        cmdValid <= 1'b0;
        cmdData  <= ~d;
        repeat ($urandom % 3) @(posedge sys_clk);
        ackReady <= 1'b1;
        do @(posedge sys_clk); while (!ackValid);
        ackReady <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== bench/net_ctrl_queue_commands_tb_top.sv ====
// Purpose: Self-checking bench of the command unit
// Assumes: Registers reached over AXI4-Lite, one access at a time
// Notes:   Expected answers queued by drivers, compared by monitor
`timescale 1ns/10ps
`default_nettype none
`include "ncq_params.svh"
`define CHK(a, x) begin checks++; if ((a) !== (x)) begin mismatches++; \
    $display("[ERR] %0t got %h exp %h", $time, a, x); end end
module net_ctrl_queue_commands_tb_top;
    logic sys_clk = 1'b0, rst = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
    logic rready = 1'b0, txValid = 1'b0, rxValid = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic [5:0] txFlow = 6'h0, rxFlow = 6'h0;
    logic [15:0] txQueue = 16'h0, rxQueue, pairsActive, p;
    logic awready, wready, bvalid, arready, rvalid, rxQueueValid;
    logic cmdValid, cmdReady, ackValid, ackReady, cfgChange;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, ex;
    logic [7:0] cmdClass, cmdCode, ackCode;
    logic [63:0] cmdData, offloadsActive, m, n;
    logic [31:0] expq[$];
    logic [3:0] cfgSeen = 4'h0;
    int mismatches = 0, checks = 0;
    always #5 sys_clk = ~sys_clk;
    ncq_cmd_unit ncq_cmd_unit_inst (.sys_clk, .rst, .awvalid, .awready,
        .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
        .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
        .cmdValid, .cmdReady, .cmdClass, .cmdCode, .cmdData, .ackValid,
        .ackReady, .ackCode, .cfgChange, .txValid, .txFlow, .txQueue,
        .rxValid, .rxFlow, .rxQueueValid, .rxQueue, .pairsActive,
        .offloadsActive);
    ncq_guest_drv ncq_guest_drv_inst (.sys_clk, .cmdValid, .cmdReady,
        .cmdClass, .cmdCode, .cmdData, .ackValid, .ackReady);
    task automatic cmp(input logic [31:0] got);
        ex = (expq.size() > 0) ? expq.pop_front() : 32'hDEAD_BEEF;
        `CHK(got, ex)
    endtask
    always @(posedge sys_clk) begin
        if (bvalid && bready) cmp({30'h0, bresp});
        if (rvalid && rready) begin
            cmp(rdata);
            cmp({30'h0, rresp});
        end
        if (cfgChange) cfgSeen++;
        if (ackValid && ackReady) cmp({24'h0, ackCode});
        if (rxQueueValid) cmp({16'h0, rxQueue});
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        logic aDone, wDone;
        expq.push_back({30'h0, r});
        aDone = 1'b0;
        wDone = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aDone && wDone)) begin
            @(posedge sys_clk);
            if (awready && !aDone) begin
                aDone = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready && !wDone) begin
                wDone = 1'b1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge sys_clk); while (!bvalid);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x,
                      input logic [1:0] r = `NCQ_RESP_OKAY);
        expq.push_back(x);
        expq.push_back({30'h0, r});
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge sys_clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge sys_clk); while (!rvalid);
        rready <= 1'b0;
    endtask
    task automatic cmd(input logic [7:0] c, input logic [63:0] d,
                       input logic [7:0] x);
        expq.push_back({24'h0, x});
        ncq_guest_drv_inst.send(c, 8'h00, d);
    endtask
    // Tx packet teaches the flow, rx packet asks for its queue
    task automatic pkt(input logic [5:0] f, input logic [15:0] q,
                       input logic [15:0] x);
        txFlow <= f;
        txQueue <= q;
        txValid <= 1'b1;
        @(posedge sys_clk);
        txValid <= 1'b0;
        expq.push_back({16'h0, x});
        rxFlow <= f;
        rxValid <= 1'b1;
        @(posedge sys_clk);
        rxValid <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic tally_and_finish;
        mismatches += expq.size();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        tally_and_finish;
    end
    initial begin
        void'($urandom(32'h5EA70877));
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd(`NCQ_REG_STATUS, 32'h0);
        rd(`NCQ_REG_PAIRS, 32'h1);
        rd(`NCQ_REG_MAX_PAIRS, 32'h1);
        rd(8'h28, 32'h0, `NCQ_RESP_SLVERR);
        wr(8'h28, 32'hFF, `NCQ_RESP_SLVERR);
        pkt(6'h3, 16'h0, 16'h0);
        wr(`NCQ_REG_FEATURES, 32'h0F, `NCQ_RESP_OKAY);
        wstrb <= 4'h1;
        wr(`NCQ_REG_MAX_PAIRS, 32'h0000_FF04, `NCQ_RESP_OKAY);
        wstrb <= 4'hF;
        wr(`NCQ_REG_ANNOUNCE, 32'h2, `NCQ_RESP_OKAY);
        rd(`NCQ_REG_STATUS, 32'h2);
        `CHK(cfgSeen, 4'h1)
        pkt(6'h1, 16'h0, 16'h0);
        cmd(`NCQ_CLASS_ANNOUNCE, 64'h0, `NCQ_ACK_OK);
        rd(`NCQ_REG_STATUS, 32'h0);
        cmd(`NCQ_CLASS_MQ, 64'h0, `NCQ_ACK_ERR);
        cmd(`NCQ_CLASS_MQ, 64'h5, `NCQ_ACK_ERR);
        rd(`NCQ_REG_PAIRS, 32'h1);
        p = 16'h2 + 16'($urandom % 3);
        cmd(`NCQ_CLASS_MQ, {48'h0, p}, `NCQ_ACK_OK);
        rd(`NCQ_REG_PAIRS, {16'h0, p});
        `CHK(pairsActive, p)
        rd(`NCQ_REG_STATUS, 32'h1);
        pkt(6'h5, p - 16'h1, p - 16'h1);
        cmd(`NCQ_CLASS_MQ, 64'h1, `NCQ_ACK_OK);
        pkt(6'h5, 16'h0, 16'h0);
        m = {$urandom, $urandom};
        wr(`NCQ_REG_OFFL_FEAT_LO, m[31:0], `NCQ_RESP_OKAY);
        wr(`NCQ_REG_OFFL_FEAT_HI, m[63:32], `NCQ_RESP_OKAY);
        rd(`NCQ_REG_OFFL_HI, m[63:32]);
        n = m & {$urandom, $urandom};
        cmd(`NCQ_CLASS_OFFLOAD, n, `NCQ_ACK_OK);
        rd(`NCQ_REG_OFFL_LO, n[31:0]);
        rd(`NCQ_REG_OFFL_HI, n[63:32]);
        `CHK(offloadsActive, n)
        cmd(8'h01, 64'h0, `NCQ_ACK_ERR);
        rd(`NCQ_REG_COUNTS, 32'h0003_0007);
        wr(`NCQ_REG_FEATURES, 32'h3F, `NCQ_RESP_OKAY);
        cmd(`NCQ_CLASS_MQ, 64'h0300, `NCQ_ACK_OK);
        rd(`NCQ_REG_PAIRS, 32'h3);
        pkt(6'h7, 16'h2, 16'h2);
        tally_and_finish;
    end
endmodule
`default_nettype wire
